/* File: verif/cmwr_checker.sv */
// Port assertions for the CAN mode and wake register bank
`timescale 1ns/10ps
module cmwr_checker (
  input logic       clk,
  input logic       rst,
  input logic       clk_en,
  input logic       reg_wr,
  input logic [6:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic       enter_sleep,
  input logic       enter_stop,
  input logic       stop_to_normal,
  input logic       enter_fail_safe,
  input logic       system_error_flag,
  input logic       fail_output,
  input logic       gp_is_wake_input,
  input logic [1:0] can_mode,
  input logic       selective_wake,
  input logic       stop_watchdog_disable_b1,
  input logic       voltage_sense_select,
  input logic       wake_pin_enable,
  input logic [1:0] gp_wake_pull_select,
  input logic [1:0] gp_pull_cfg_eff,
  input logic       wake_pin_level_status,
  input logic       gp_pin_level_status,
  input logic       spi_fail_set
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  // Hardware updates only judged when no write competes, save the stop clear and level hold checks
  wire hw = clk_en && !reg_wr;
  AST_SLEEP_NORM: assert property (hw && enter_sleep && !system_error_flag && can_mode == 2'h3
    |=> can_mode == 2'h1) else $error("sleep kept normal mode");
  AST_STOP_RXO: assert property (hw && enter_stop && can_mode == 2'h2 |=> can_mode == 2'h2)
    else $error("stop left receive only");
  AST_SWK_HOLD: assert property (hw |=> $stable(selective_wake))
    else $error("selective wake changed without a write");
  AST_FS_BUS: assert property (hw && enter_fail_safe |=> can_mode == 2'h1)
    else $error("fail-safe mode not wake capable");
  AST_SENSE_REJ: assert property (clk_en && reg_wr && reg_addr == 7'h07 && reg_wdata[5]
    && fail_output |=> !voltage_sense_select && spi_fail_set) else $error("sense write kept");
  AST_WK_GATE: assert property (voltage_sense_select && !fail_output |-> !wake_pin_enable)
    else $error("wake pin enabled while sensing");
  AST_GP_PULL: assert property (!gp_is_wake_input |-> gp_wake_pull_select == 2'h0)
    else $error("gp pull active while not wake input");
  AST_STOP_CLR: assert property (clk_en && stop_to_normal |=> !stop_watchdog_disable_b1)
    else $error("stop watchdog bit not cleared");
  AST_LVL_HOLD: assert property (clk_en && voltage_sense_select
    |=> !wake_pin_level_status && !gp_pin_level_status) else $error("level live while sensing");
  AST_GP_EFF: assert property (voltage_sense_select && !fail_output |-> gp_pull_cfg_eff == 2'h0)
    else $error("gp config live while sensing");
endmodule
bind cmwr_regs cmwr_checker u_chk (.*);

/* File: verif/cmwr_host.sv */
// Serial host model issuing single register accesses
`timescale 1ns/10ps
module cmwr_host (
  input  logic       clk,
  input  logic [7:0] reg_rdata,
  output logic       reg_wr = 1'b0,
  output logic       reg_rd = 1'b0,
  output logic [6:0] reg_addr = 7'h00,
  output logic [7:0] reg_wdata = 8'h00
);
  // One strobe held over its taking edge; released bus shows inverted data
  task automatic xfer(input logic w, input logic [6:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge clk);
    #5;
    reg_wr = w;
    reg_rd = !w;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk);
    #5;
    q = reg_rdata;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
endmodule

/* File: verif/cmwr_regs_tb_top.sv */
// Self-checking bench for the CAN mode and wake register bank
`timescale 1ns/10ps
module cmwr_regs_tb_top;
  import cmwr_pkg::*;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       dev_mode = 1'b0;
  logic       fail_output = 1'b0;
  logic       gp_is_wake_input = 1'b0;
  logic       wake_pin_raw_level = 1'b1;
  logic       gp_pin_raw_level = 1'b1;
  logic [5:0] ev = 6'h00;
  logic [1:0] gp_pull_cfg_in = 2'h3;
  logic       clk_en = 1'b1;
  logic       system_error_flag = 1'b0;
  logic       timer_event = 1'b0;
  logic       can_wake_event = 1'b0;
  logic       reg_wr, reg_rd, selective_wake, can_wake_source, timer_wake_enable;
  logic       stop_watchdog_disable_b1, interrupt_out_n, voltage_sense_select;
  logic       wake_pin_enable, spi_fail_set, wake_pin_level_status, gp_pin_level_status;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, q;
  logic [1:0] can_mode, wake_pin_pull_select, gp_wake_pull_select, gp_pull_cfg_eff;
  wire        enter_sleep, enter_stop, stop_to_normal, enter_fail_safe;
  wire        wake_pin_event, other_status_event;
  int         n_mismatch = 0;
  int         compares = 0;
  int         cycles = 0;
  logic [6:0] ra [5] = '{7'h04, 7'h06, 7'h07, 7'h08, 7'h05};
  logic [7:0] rv [5] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
  logic [7:0] mk [5] = '{8'h07, 8'h44, 8'ha1, 8'hc3, 8'h00};
  ////////////////////////////////////////////////////////////
  // Event strobes packed so one assignment moves them all
  assign {enter_sleep, enter_stop, stop_to_normal, enter_fail_safe} = ev[5:2];
  assign {wake_pin_event, other_status_event} = ev[1:0];
  always #25 clk = ~clk;
  cmwr_regs DUT (.*);
  cmwr_host u_host (.*);
  // Hang guard, far above the under two hundred cycles needed
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      n_mismatch++;
      test_done;
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    u_host.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] x, input string nm);
    u_host.xfer(1'b0, a, 8'h00, q);
    chk(nm, x, q);
  endtask
  task automatic tick;
    @(posedge clk);
    #5;
  endtask
  // Events stand for exactly one edge
  task automatic pulse(input logic [5:0] e);
    tick;
    ev = e;
    tick;
    ev = 6'h00;
  endtask
  task automatic lp(input logic [7:0] m, input logic [5:0] e, input logic [7:0] x);
    wr(7'h04, m);
    pulse(e);
    rd(7'h04, x, "bus mode");
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_access;
    for (int i = 0; i < 5; i++) rd(ra[i], rv[i], "reset value");
    for (int i = 0; i < 5; i++) begin
      wr(ra[i], 8'hff);
      rd(ra[i], mk[i], "masked");
    end
    chk("timer wake", 8'h01, {7'h0, timer_wake_enable});
    u_host.xfer(1'b1, 7'h04, 8'h00, q);
    chk("old data", 8'h07, q);
    gp_is_wake_input = 1'b1;
    tick;
    chk("pulls", 8'h0f, {4'h0, gp_wake_pull_select, wake_pin_pull_select});
    chk("sense gate", 8'h00, {5'h0, wake_pin_enable, gp_pull_cfg_eff});
    chk("level held", 8'h00, {6'h0, wake_pin_level_status, gp_pin_level_status});
    wr(7'h07, 8'h01);
    tick;
    chk("wake on", 8'h07, {5'h0, wake_pin_enable, gp_pull_cfg_eff});
    chk("level live", 8'h03, {6'h0, wake_pin_level_status, gp_pin_level_status});
    pulse(6'h01);
    chk("int other", 8'h01, {7'h0, interrupt_out_n});
    pulse(6'h02);
    chk("int wake", 8'h00, {7'h0, interrupt_out_n});
    wr(7'h07, 8'h81);
    pulse(6'h01);
    chk("int global", 8'h00, {7'h0, interrupt_out_n});
    $display("access done");
  endtask
  task automatic t_modes;
    for (logic [3:0] c = 0; c < 8; c++) begin
      wr(7'h04, {4'h0, c});
      chk("mode", {4'h0, c[1:0] == 2'h1, c[2:0]},
          {4'h0, can_wake_source, selective_wake, can_mode});
    end
    $display("modes done");
  endtask
  task automatic t_lowpow;
    lp(8'h03, 6'h20, 8'h01);
    lp(8'h07, 6'h20, 8'h05);
    lp(8'h02, 6'h10, 8'h02);
    lp(8'h02, 6'h20, 8'h01);
    lp(8'h00, 6'h20, 8'h00);
    lp(8'h01, 6'h10, 8'h01);
    system_error_flag = 1'b1;
    lp(8'h03, 6'h20, 8'h03);
    lp(8'h02, 6'h20, 8'h01);
    system_error_flag = 1'b0;
    $display("low power done");
  endtask
  task automatic t_wake;
    wr(7'h06, 8'h04);
    chk("stop wd bit", 8'h01, {7'h0, stop_watchdog_disable_b1});
    fork
      wr(7'h06, 8'h44);
      begin
        tick;
        ev = 6'h08;
        tick;
        ev = 6'h00;
      end
    join
    rd(7'h06, 8'h40, "clear wins");
    timer_event = 1'b1;
    tick;
    timer_event = 1'b0;
    chk("int timer", 8'h00, {7'h0, interrupt_out_n});
    wr(7'h06, 8'h00);
    wr(7'h04, 8'h03);
    timer_event = 1'b1;
    can_wake_event = 1'b1;
    tick;
    timer_event = 1'b0;
    can_wake_event = 1'b0;
    chk("int off", 8'h01, {7'h0, interrupt_out_n});
    wr(7'h04, 8'h05);
    can_wake_event = 1'b1;
    tick;
    can_wake_event = 1'b0;
    chk("int can", 8'h00, {7'h0, interrupt_out_n});
    wr(7'h07, 8'h21);
    chk("sense on", 8'h01, {7'h0, voltage_sense_select});
    fail_output = 1'b1;
    pulse(6'h02);
    chk("int sensing", 8'h01, {7'h0, interrupt_out_n});
    fail_output = 1'b0;
    clk_en = 1'b0;
    wr(7'h04, 8'h07);
    pulse(6'h04);
    clk_en = 1'b1;
    rd(7'h04, 8'h05, "frozen");
    $display("wake done");
  endtask
  task automatic t_fail;
    wr(7'h07, 8'h80);
    lp(8'h07, 6'h04, 8'h05);
    rd(7'h07, 8'h81, "ext fail-safe");
    wr(7'h07, 8'ha0);
    pulse(6'h04);
    rd(7'h07, 8'ha0, "ext sensing");
    fail_output = 1'b1;
    wr(7'h07, 8'h21);
    chk("spi fail", 8'h01, {7'h0, spi_fail_set});
    rd(7'h07, 8'h01, "sense refused");
    fail_output = 1'b0;
    wr(7'h06, 8'h44);
    pulse(6'h08);
    rd(7'h06, 8'h40, "stop clear");
    dev_mode = 1'b1;
    rst = 1'b1;
    repeat (3) tick;
    rst = 1'b0;
    rd(7'h04, 8'h03, "dev reset");
    $display("fail-safe done");
  endtask
  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (3) tick;
    rst = 1'b0;
    t_access;
    t_modes;
    t_lowpow;
    t_wake;
    t_fail;
    test_done;
  end
endmodule

/* File: verilog/cmwr_pkg.sv */
// Constants for the CAN mode and wake source register bank
package cmwr_pkg;

  // Register addresses (7-bit serial interface address)
  localparam logic [6:0] ADDR_BUS_MODE  = 7'h04;
  localparam logic [6:0] ADDR_INT_WAKE  = 7'h06;
  localparam logic [6:0] ADDR_EXT_WAKE  = 7'h07;
  localparam logic [6:0] ADDR_PULL_CTRL = 7'h08;

  // Reset values
  localparam logic [7:0] RST_BUS_MODE   = 8'h00;
  localparam logic [7:0] RST_BUS_DEV    = 8'h03;
  localparam logic [7:0] RST_INT_WAKE   = 8'h00;
  localparam logic [7:0] RST_EXT_WAKE   = 8'h01;
  localparam logic [7:0] RST_PULL_CTRL  = 8'h00;

  // Writable bit masks, reserved bits stay zero
  localparam logic [7:0] MASK_BUS_MODE  = 8'h07;
  localparam logic [7:0] MASK_INT_WAKE  = 8'h44;
  localparam logic [7:0] MASK_EXT_WAKE  = 8'ha1;
  localparam logic [7:0] MASK_PULL_CTRL = 8'hc3;

  // Fail-safe patterns
  localparam logic [7:0] FS_BUS_MODE    = 8'h01;
  localparam logic [7:0] FS_EXT_WAKE    = 8'h01;
  localparam logic [7:0] FS_EXT_KEEP    = 8'ha0;

  // Field positions
  localparam int BUS_SWK_BIT  = 2;
  localparam int TMR_WK_BIT   = 6;
  localparam int WD_STOP1_BIT = 2;
  localparam int INT_GLB_BIT  = 7;
  localparam int MEAS_BIT     = 5;
  localparam int WAKE_PIN_ENABLE_BIT    = 0;
  localparam int WK_PULL_LO   = 0;
  localparam int GP_PULL_LO   = 6;

  // Transceiver mode codes (low two bits)
  typedef enum logic [1:0] {
    CMWR_CAN_OFF  = 2'h0,
    CMWR_CAN_WAKE = 2'h1,
    CMWR_CAN_RXO  = 2'h2,
    CMWR_CAN_NORM = 2'h3
  } cmwr_can_e;

  // Pull selections
  typedef enum logic [1:0] {
    CMWR_PULL_NONE = 2'h0,
    CMWR_PULL_DOWN = 2'h1,
    CMWR_PULL_UP   = 2'h2,
    CMWR_PULL_AUTO = 2'h3
  } cmwr_pull_e;

endpackage

/* File: verilog/cmwr_regs.sv */
// CAN transceiver mode and wake source control register bank
`timescale 1ns/10ps

module cmwr_regs
  import cmwr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  input  wire logic        dev_mode,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [6:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  input  wire logic        enter_sleep,
  input  wire logic        enter_stop,
  input  wire logic        stop_to_normal,
  input  wire logic        enter_fail_safe,
  input  wire logic        system_error_flag,
  input  wire logic        fail_output,
  input  wire logic        gp_is_wake_input,
  input  wire logic        wake_pin_event,
  input  wire logic        timer_event,
  input  wire logic        can_wake_event,
  input  wire logic        other_status_event,
  input  wire logic        wake_pin_raw_level,
  input  wire logic        gp_pin_raw_level,
  input  wire logic [1:0]  gp_pull_cfg_in,
  output logic      [1:0]  can_mode,
  output logic             selective_wake,
  output logic             can_wake_source,
  output logic             timer_wake_enable,
  output logic             stop_watchdog_disable_b1,
  output logic             interrupt_out_n,
  output logic             voltage_sense_select,
  output logic             wake_pin_enable,
  output logic             wake_pin_level_status,
  output logic             gp_pin_level_status,
  output logic      [1:0]  wake_pin_pull_select,
  output logic      [1:0]  gp_wake_pull_select,
  output logic      [1:0]  gp_pull_cfg_eff,
  output logic             spi_fail_set
);

  logic [7:0] bus_transceiver_mode_ff;
  logic [7:0] internal_wake_control_ff;
  logic [7:0] external_wake_control_ff;
  logic [7:0] wake_input_pull_control_ff;
  logic       wake_pin_level_ff;
  logic       gp_pin_level_ff;
  logic       int_n_ff;
  logic       spi_fail_ff;
  logic       nxt_int_n;
  logic [1:0] nxt_can;
  logic [7:0] rdata_ff;
  logic       wr_bus;
  logic       wr_int;
  logic       wr_ext;
  logic       wr_pull;
  logic       meas_rejected;

  //////////////////////////////////////////////////////////////////////////
  // Write decode
  // One strobe is one access; the address picks a single register, so at
  // most one of these selects is high in any cycle
  assign wr_bus  = reg_wr && (reg_addr == ADDR_BUS_MODE);
  assign wr_int  = reg_wr && (reg_addr == ADDR_INT_WAKE);
  assign wr_ext  = reg_wr && (reg_addr == ADDR_EXT_WAKE);
  assign wr_pull = reg_wr && (reg_addr == ADDR_PULL_CTRL);
  // sense write check
  // Judged on the data being written, not on the stored bit, so a refused
  // write pulses the failure flag even when sensing was already off
  assign meas_rejected = wr_ext && fail_output && reg_wdata[MEAS_BIT];

  //////////////////////////////////////////////////////////////////////////
  // Low-power entry update of the mode bits; fail-safe handled separately
  // Sleep and stop arrive as one-cycle strobes from the mode controller;
  // should both ever coincide, sleep is honoured first
  always_comb begin
    nxt_can = bus_transceiver_mode_ff[1:0];
    if (enter_sleep && !system_error_flag && nxt_can == CMWR_CAN_NORM) begin
      nxt_can = CMWR_CAN_WAKE;
    end
    else if (enter_sleep && nxt_can == CMWR_CAN_RXO) begin
      nxt_can = CMWR_CAN_WAKE;
    end
    // stop entry keeps receive only; leaves the choice to software
    else if (enter_stop) begin
      nxt_can = bus_transceiver_mode_ff[1:0];
    end
    // off and wake kept; stop keeps receive only, relies on software
  end

  //////////////////////////////////////////////////////////////////////////
  // Bus transceiver mode; development reset to normal
  // Priority is write, then fail-safe, then low-power entry. Trade-off: a
  // write landing in the fail-safe cycle replaces the wake pattern, so
  // firmware should not write this register while a failure is pending
  always_ff @(posedge clk) begin
    if (rst) begin
      bus_transceiver_mode_ff <= RST_BUS_MODE;
      // Development strap only matters while reset is held
      if (dev_mode) begin
        bus_transceiver_mode_ff <= RST_BUS_DEV;
      end
    end else if (clk_en) begin
      if (wr_bus) begin
        bus_transceiver_mode_ff <= reg_wdata & MASK_BUS_MODE;
      end else if (enter_fail_safe) begin
        // fail-safe wake pattern; keeps selective wake bit
        bus_transceiver_mode_ff <= {5'h00, bus_transceiver_mode_ff[BUS_SWK_BIT],
                                    FS_BUS_MODE[1:0]};
      end else begin
        bus_transceiver_mode_ff[1:0] <= nxt_can;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Internal wake control
  // The stop exit clear comes after the write so that it overrides a
  // same-cycle write that tries to keep the watchdog off
  always_ff @(posedge clk) begin
    if (rst) begin
      internal_wake_control_ff <= RST_INT_WAKE;
    end else if (clk_en) begin
      if (wr_int) begin
        internal_wake_control_ff <= reg_wdata & MASK_INT_WAKE;
      end
      // cleared on stop exit, hardware wins over write
      if (stop_to_normal) begin
        internal_wake_control_ff[WD_STOP1_BIT] <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // External wake control
  // Fail-safe keeps the global and sense bits and turns pin wake on; with
  // sensing selected the pin cannot wake, so the register is left alone
  always_ff @(posedge clk) begin
    if (rst) begin
      external_wake_control_ff <= RST_EXT_WAKE;
    end else if (clk_en) begin
      if (wr_ext) begin
        external_wake_control_ff <= reg_wdata & MASK_EXT_WAKE;
        if (fail_output) begin
          external_wake_control_ff[MEAS_BIT] <= 1'b0;
        end
      end else if (enter_fail_safe && !external_wake_control_ff[MEAS_BIT]) begin
        external_wake_control_ff <= (external_wake_control_ff & FS_EXT_KEEP) | FS_EXT_WAKE;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Pull control, plain storage
  // Pads outside decode the fields; the reserved middle bits are masked
  // on the way in so they read back as zero
  always_ff @(posedge clk) begin
    if (rst) begin
      wake_input_pull_control_ff <= RST_PULL_CTRL;
    end else if (clk_en && wr_pull) begin
      wake_input_pull_control_ff <= reg_wdata & MASK_PULL_CTRL;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Level status; sensing uses the pin, so its levels are meaningless
  // Limitation: after sensing is switched off the first live level shows
  // one cycle late, since the flop still sees the old select
  always_ff @(posedge clk) begin
    if (rst) begin
      wake_pin_level_ff <= 1'b0;
      gp_pin_level_ff   <= 1'b0;
    end else if (clk_en) begin
      if (voltage_sense_select) begin
        wake_pin_level_ff <= 1'b0;
        gp_pin_level_ff   <= 1'b0;
      end else begin
        wake_pin_level_ff <= wake_pin_raw_level;
        gp_pin_level_ff   <= gp_pin_raw_level;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Interrupt request, one-cycle low per event
  // Limitation: events in one cycle merge into a single low pulse
  always_comb begin
    nxt_int_n = 1'b1;
    // pin wake gating
    // Sensing blocks pin wakes outright, even with the fail output active
    // where the enable bit itself is honoured again
    if (wake_pin_event && wake_pin_enable && !voltage_sense_select) begin
      nxt_int_n = 1'b0;
    end
    if (timer_event && timer_wake_enable) begin
      nxt_int_n = 1'b0;
    end
    if (can_wake_event && can_wake_source) begin
      nxt_int_n = 1'b0;
    end
    if (other_status_event && external_wake_control_ff[INT_GLB_BIT]) begin
      nxt_int_n = 1'b0;
    end
  end

  // Registered so the interrupt pin never glitches while events settle
  // The failure flag is a pulse; the status register outside latches it
  always_ff @(posedge clk) begin
    if (rst) begin
      int_n_ff    <= 1'b1;
      spi_fail_ff <= 1'b0;
    end else if (clk_en) begin
      int_n_ff    <= nxt_int_n;
      spi_fail_ff <= meas_rejected;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read data; captured before the same-cycle write lands
  // Reads and writes both load the read register, so every access answers
  // with the contents as they stood before its strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_ff <= 8'h00;
    end else if (clk_en && (reg_rd || reg_wr)) begin
      // reserved reads zero via masked storage
      case (reg_addr)
        ADDR_BUS_MODE:  rdata_ff <= bus_transceiver_mode_ff;
        ADDR_INT_WAKE:  rdata_ff <= internal_wake_control_ff;
        ADDR_EXT_WAKE:  rdata_ff <= external_wake_control_ff;
        ADDR_PULL_CTRL: rdata_ff <= wake_input_pull_control_ff;
        default:        rdata_ff <= 8'h00;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs
  // mode decode
  assign can_mode                 = bus_transceiver_mode_ff[1:0];
  assign selective_wake           = bus_transceiver_mode_ff[BUS_SWK_BIT];
  // wake source only in the wake capable code
  assign can_wake_source          = (bus_transceiver_mode_ff[1:0] == CMWR_CAN_WAKE);
  assign timer_wake_enable        = internal_wake_control_ff[TMR_WK_BIT];
  assign stop_watchdog_disable_b1 = internal_wake_control_ff[WD_STOP1_BIT];
  assign voltage_sense_select     = external_wake_control_ff[MEAS_BIT];
  assign wake_pin_enable          = external_wake_control_ff[WAKE_PIN_ENABLE_BIT]
                                    && !(voltage_sense_select && !fail_output);
  // gp config ignored while sensing with the fail output low
  // Forced to no pull rather than held, so the pad falls to a known state
  assign gp_pull_cfg_eff          = (voltage_sense_select && !fail_output)
                                    ? 2'h0 : gp_pull_cfg_in;
  assign interrupt_out_n          = int_n_ff;
  assign spi_fail_set             = spi_fail_ff;
  assign wake_pin_level_status    = wake_pin_level_ff;
  assign gp_pin_level_status      = gp_pin_level_ff;
  assign reg_rdata                = rdata_ff;
  // pull field
  // Code 11 lets the pad pick up or down from the pin level
  assign wake_pin_pull_select     = wake_input_pull_control_ff[WK_PULL_LO +: 2];
  // gp pull only as wake input
  assign gp_wake_pull_select      = gp_is_wake_input
                                    ? wake_input_pull_control_ff[GP_PULL_LO +: 2]
                                    : CMWR_PULL_NONE;

endmodule
